// ### verilog/ubd_map.vh
`ifndef UBD_MAP_VH
`define UBD_MAP_VH

// ---------------------------------------------------------------
// register offsets (word index, byte address = index * 4)
// ---------------------------------------------------------------
`define UBD_OFS_DIV_LOW    3'h0
`define UBD_OFS_DIV_HIGH   3'h1
`define UBD_OFS_EXT_ONE    3'h2
`define UBD_OFS_LINE_CTRL  3'h3
`define UBD_OFS_EXT_TWO    3'h4
`define UBD_OFS_MODEM_CTRL 3'h4
`define UBD_OFS_RSVD5      3'h5
`define UBD_OFS_TX_LEVEL   3'h6
`define UBD_OFS_RX_LEVEL   3'h7
`define UBD_ADR_LSB        2
`define UBD_ADR_MSB        4

// ---------------------------------------------------------------
// bank select and field positions
// ---------------------------------------------------------------
`define UBD_BANK_LEGACY    2'h1
`define UBD_BANK_EXT       2'h2
`define UBD_LCR_BANK_BIT   7
`define UBD_BSR_CODE_B2    8'hE0
`define UBD_BSR_CODE_B3    8'hE4
`define UBD_EXT1_SEL       0
`define UBD_EXT1_LOOP      4
`define UBD_EXT1_LBTX      5
`define UBD_EXT1_BAUD_GENERATOR_TEST_BIT     7
`define UBD_EXT2_LOCK      7
`define UBD_MCR_DTR        0
`define UBD_MCR_RTS        1
`define UBD_MCR_OUT1       2
`define UBD_MCR_OUT2       3
`define UBD_MCR_LOOP       4

// ---------------------------------------------------------------
// writable masks and fallback clear masks
// ---------------------------------------------------------------
`define UBD_EXT1_WMASK     8'hB1
`define UBD_EXT2_WMASK     8'hB0
`define UBD_FB_EXT_MCR     8'h03
`define UBD_FB_EXT_EXT1    8'h5E
`define UBD_FB_EXT_EXT2    8'hC0
`define UBD_FB_NEX_EXT1    8'h5F
`define UBD_ZERO8          8'h00

// ---------------------------------------------------------------
// prescaler codes and fractional ratios (numer/denom)
// ---------------------------------------------------------------
`define UBD_PRE_13         2'h0
`define UBD_PRE_1P625      2'h1
`define UBD_PRE_RSVD       2'h2
`define UBD_PRE_1          2'h3
`define UBD_PRE13_NUM      5'h0D
`define UBD_PRE13_DEN      5'h01
`define UBD_PRE1625_NUM    5'h0D
`define UBD_PRE1625_DEN    5'h08
`define UBD_PRE1_NUM       5'h01
`define UBD_PRE1_DEN       5'h01
`define UBD_DIV_ONE        16'h0001
`define UBD_DIV_ZERO       16'h0000

`endif

// ### verilog/ubd_prescaler.v
`timescale 1ns/1ps
`default_nettype none
`include "ubd_map.vh"

// fractional prescaler: pulses at clk*den/num using an accumulator
module ubd_prescaler (
	input  wire       clk,
	input  wire       rst_n,
	input  wire [1:0] preSel,
	output reg        preTick
);

	reg  [4:0] accQ;
	reg  [4:0] accD;
	reg  [4:0] num;
	reg  [4:0] den;
	wire [5:0] sum;

	// --------------------------------------------------------
	// ratio select
	// --------------------------------------------------------
	always @* begin
		case (preSel)
			`UBD_PRE_13: begin
				num = `UBD_PRE13_NUM;
				den = `UBD_PRE13_DEN;
			end
			`UBD_PRE_1P625: begin
				num = `UBD_PRE1625_NUM;
				den = `UBD_PRE1625_DEN;
			end
			default: begin // reserved code behaves as 1
				num = `UBD_PRE1_NUM;
				den = `UBD_PRE1_DEN;
			end
		endcase
	end

	assign sum = {1'b0, accQ} + {1'b0, den};

	// accumulate; one tick each time the sum reaches num
	always @* begin
		if (sum >= {1'b0, num})
			accD = sum[4:0] - num;
		else
			accD = sum[4:0];
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			accQ    <= 5'h00;
			preTick <= 1'b0;
		end else begin
			accQ    <= (accD >= num) ? 5'h00 : accD;
			preTick <= (sum >= {1'b0, num}); // [RULE3]
		end
	end

endmodule
`default_nettype wire

// ### verilog/ubd_baud_counter.v
`timescale 1ns/1ps
`default_nettype none
`include "ubd_map.vh"

// divisor counter giving one 16x pulse per expiry
module ubd_baud_counter (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        preTick,
	input  wire [15:0] divisor,
	input  wire        loadNow,
	output reg         baudX16
);

	reg [15:0] cntQ;

	// --------------------------------------------------------
	// count down on prescaled ticks, reload on expiry or write
	// --------------------------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cntQ    <= `UBD_DIV_ONE;
			baudX16 <= 1'b0;
		end else if (loadNow) begin
			cntQ    <= divisor; // [RULE6]
			baudX16 <= 1'b0;
		end else if (preTick) begin
			if (cntQ <= `UBD_DIV_ONE) begin
				cntQ    <= divisor; // [RULE23]
				baudX16 <= 1'b1;    // [RULE4]
			end else begin
				cntQ    <= cntQ - `UBD_DIV_ONE;
				baudX16 <= 1'b0;
			end
		end else begin
			baudX16 <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ### verilog/ubd_top.v
`timescale 1ns/1ps
`default_nettype none
`include "ubd_map.vh"

// Operation
// RULE1: offsets 0 and 1 reach data ports or legacy divisor per bank bit
// RULE2: any legacy divisor access falls back to non-extended mode
// RULE3: baud input is 24 MHz over prescale 13, 1.625 or 1
// RULE4: divisor divides prescaled clock to 16x baud pulse
// RULE5: software never programs divisor zero
// RULE6: writing either divisor byte reloads the counter at once
// RULE7: divisor storage is not reset
// RULE8: non-extended with lock set: legacy access changes nothing
// RULE9: fallback clears mode-dependent bits of modem and extended controls
// RULE10: alternate divisor pair sets same divisor, never changes mode
// RULE11: alternate high byte write changes baud rate immediately
// RULE12: non-legacy software should use the alternate divisor pair
// RULE13: extended control one bit 0 selects extended mode, resets zero
// RULE14: loopback bit shared with modem control bit 4; code copies modem control bit 4 writes into it only in non-extended mode
// RULE15: extended loopback: terminal ready feeds set-ready/ring, rts feeds cts/dcd
// RULE16: loopback disconnects receive pins, feeds receivers from transmitters
// RULE17: loopback holds wired tx high, infrared tx low, unless enabled
// RULE18: loopback modem status comes from lower modem control bits
// RULE19: loopback transmit enable keeps serial output normal
// RULE20: baud test bit routes 16x clock to terminal-ready pin
// RULE21: prescaler field bits 5:4; 00=13, 01=1.625, 11=1
// RULE22: lock set: legacy ports reach two scratchpad bytes, no fallback; code does so only in non-extended mode, extended mode still falls back
// RULE23: counter reloads and pulses once per expiry
module ubd_top (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [4:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire [7:0]  dataPortRd,
	output wire        dataPortRdStb,
	output wire        dataPortWrStb,
	output reg  [7:0]  dataPortWrData,
	input  wire [4:0]  txFifoLevel,
	input  wire [4:0]  rxFifoLevel,
	input  wire        txSerialInt,
	input  wire        txIrInt,
	output wire        txSerialPin,
	output wire        txIrPin,
	input  wire        rxSerialPin,
	input  wire        rxIrPin,
	output wire        rxSerialInt,
	output wire        rxIrInt,
	input  wire        ctsPin,
	input  wire        dsrPin,
	input  wire        riPin,
	input  wire        dcdPin,
	output wire        ctsInt,
	output wire        dsrInt,
	output wire        riInt,
	output wire        dcdInt,
	output wire        dtrPin,
	output wire        rtsPin,
	output wire        baudX16,
	output wire        extMode,
	output wire        loopEn,
	output wire [7:0]  lineCtrl,
	output wire [7:0]  modemCtrl
);

	// -----------------------------------------------------------
	// state
	// -----------------------------------------------------------
	reg  [7:0]  lcrQ;
	reg  [1:0]  bankQ;
	reg  [7:0]  ext1Q;
	reg  [7:0]  ext2Q;
	reg  [7:0]  mcrQ;
	reg  [15:0] divQ;
	reg  [7:0]  scrLowQ;
	reg  [7:0]  scrHighQ;
	reg         loadQ;
	reg  [7:0]  wrByte;
	wire        acc;
	wire [2:0]  idx;
	wire        legacyBank;
	wire        extBank;
	wire        divBank;
	wire        hitLegacy;
	wire        hitAlt;
	wire        locked;
	wire        fbExt;
	wire        fbNonExt;
	wire        loopMode;

	assign acc       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign idx       = wb_adr_i[`UBD_ADR_MSB:`UBD_ADR_LSB];
	assign legacyBank = (bankQ == `UBD_BANK_LEGACY);
	assign extBank   = (bankQ == `UBD_BANK_EXT);
	assign divBank   = lcrQ[`UBD_LCR_BANK_BIT];
	assign extMode   = ext1Q[`UBD_EXT1_SEL];
	assign locked    = ext2Q[`UBD_EXT2_LOCK];
	assign loopMode  = ext1Q[`UBD_EXT1_LOOP];
	assign loopEn    = loopMode;
	assign lineCtrl  = lcrQ;
	assign modemCtrl = mcrQ;

	// legacy divisor port hit: bank 1, or bank bit set in legacy map
	assign hitLegacy = acc & (idx <= `UBD_OFS_DIV_HIGH)
		& (legacyBank | (divBank & ~extBank)); // [RULE1]
	assign hitAlt    = acc & extBank & (idx <= `UBD_OFS_DIV_HIGH);

	// fallback flavours; none when non-extended and locked
	assign fbExt    = hitLegacy & extMode;              // [RULE2]
	assign fbNonExt = hitLegacy & ~extMode & ~locked;   // [RULE8]

	// data port strobes when bank bit clear in bank 0
	assign dataPortRdStb = acc & ~wb_we_i & ~divBank & ~legacyBank & ~extBank
		& (idx == `UBD_OFS_DIV_LOW); // [RULE1]
	assign dataPortWrStb = acc & wb_we_i & ~divBank & ~legacyBank & ~extBank
		& (idx == `UBD_OFS_DIV_LOW);

	always @* begin
		wrByte = wb_sel_i[0] ? wb_dat_i[7:0] : `UBD_ZERO8;
	end

	// -----------------------------------------------------------
	// control registers
	// -----------------------------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lcrQ     <= `UBD_ZERO8;
			bankQ    <= 2'h0;
			ext1Q    <= `UBD_ZERO8; // [RULE13]
			ext2Q    <= `UBD_ZERO8;
			mcrQ     <= `UBD_ZERO8;
			wb_ack_o <= 1'b0;
			loadQ    <= 1'b0;
			dataPortWrData <= `UBD_ZERO8;
		end else begin
			wb_ack_o <= acc;
			loadQ    <= 1'b0;
			if (acc & wb_we_i & wb_sel_i[0]) begin
				if (idx == `UBD_OFS_LINE_CTRL) begin
					lcrQ <= wrByte;
					if (wrByte == `UBD_BSR_CODE_B2)
						bankQ <= `UBD_BANK_EXT;
					else if (wrByte[`UBD_LCR_BANK_BIT])
						bankQ <= `UBD_BANK_LEGACY;
					else
						bankQ <= 2'h0;
				end
				if (extBank & (idx == `UBD_OFS_EXT_ONE))
					ext1Q <= wrByte & `UBD_EXT1_WMASK; // [RULE13]
				if (extBank & (idx == `UBD_OFS_EXT_TWO))
					ext2Q <= wrByte & `UBD_EXT2_WMASK; // [RULE21]
				if (~extBank & ~legacyBank & (idx == `UBD_OFS_MODEM_CTRL)) begin
					mcrQ <= wrByte;
					if (~extMode)
						ext1Q[`UBD_EXT1_LOOP] <= wrByte[`UBD_MCR_LOOP]; // [RULE14]
				end
				if (dataPortWrStb)
					dataPortWrData <= wrByte;
				if ((hitLegacy & ~(~extMode & locked)) | hitAlt)
					loadQ <= 1'b1; // [RULE11]
			end
			// fallback on any legacy access, read or write, unless non-extended and locked
			if (fbExt) begin
				mcrQ  <= mcrQ & `UBD_FB_EXT_MCR;   // [RULE9]
				ext1Q <= ext1Q & `UBD_FB_EXT_EXT1;
				ext2Q <= ext2Q & `UBD_FB_EXT_EXT2;
			end else if (fbNonExt) begin
				ext1Q <= ext1Q & `UBD_FB_NEX_EXT1; // [RULE9]
				ext2Q <= ext2Q & `UBD_FB_EXT_EXT2;
			end
		end
	end

	// -----------------------------------------------------------
	// divisor and scratchpad storage, no reset
	// -----------------------------------------------------------
	always @(posedge clk) begin
		if (acc & wb_we_i & wb_sel_i[0]) begin
			if (hitAlt | (hitLegacy & ~(~extMode & locked))) begin // [RULE10]
				if (idx == `UBD_OFS_DIV_LOW)
					divQ[7:0] <= wrByte; // [RULE7]
				else
					divQ[15:8] <= wrByte;
			end
			if (hitLegacy & ~extMode & locked) begin // [RULE22]
				if (idx == `UBD_OFS_DIV_LOW)
					scrLowQ <= wrByte;
				else
					scrHighQ <= wrByte;
			end
		end
	end

	// -----------------------------------------------------------
	// read mux
	// -----------------------------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_dat_o <= 32'h00000000;
		end else if (acc & ~wb_we_i) begin
			wb_dat_o <= 32'h00000000;
			if (hitLegacy & ~extMode & locked)
				wb_dat_o[7:0] <= (idx == `UBD_OFS_DIV_LOW) ? scrLowQ : scrHighQ;
			else if (hitLegacy | hitAlt)
				wb_dat_o[7:0] <= (idx == `UBD_OFS_DIV_LOW) ? divQ[7:0] : divQ[15:8];
			else if (idx == `UBD_OFS_LINE_CTRL)
				wb_dat_o[7:0] <= lcrQ;
			else if (extBank) begin
				case (idx)
					`UBD_OFS_EXT_ONE:  wb_dat_o[7:0] <= ext1Q;
					`UBD_OFS_EXT_TWO:  wb_dat_o[7:0] <= ext2Q;
					`UBD_OFS_TX_LEVEL: wb_dat_o[4:0] <= txFifoLevel;
					`UBD_OFS_RX_LEVEL: wb_dat_o[4:0] <= rxFifoLevel;
					default:           wb_dat_o[7:0] <= `UBD_ZERO8;
				endcase
			end else if (~legacyBank) begin
				if (idx == `UBD_OFS_DIV_LOW)
					wb_dat_o[7:0] <= dataPortRd;
				else if (idx == `UBD_OFS_MODEM_CTRL)
					wb_dat_o[7:0] <= mcrQ;
			end
		end
	end

	// -----------------------------------------------------------
	// baud generation
	// -----------------------------------------------------------
	wire preTick;

	ubd_prescaler uPre (
		.clk     (clk),
		.rst_n   (rst_n),
		.preSel  (ext2Q[5:4]), // [RULE3]
		.preTick (preTick)
	);

	ubd_baud_counter uCnt (
		.clk     (clk),
		.rst_n   (rst_n),
		.preTick (preTick),
		.divisor (divQ),
		.loadNow (loadQ), // [RULE6]
		.baudX16 (baudX16)
	);

	// -----------------------------------------------------------
	// loopback routing
	// -----------------------------------------------------------
	wire txOn;
	assign txOn = ~loopMode | ext1Q[`UBD_EXT1_LBTX]; // [RULE19]

	assign txSerialPin = txOn ? txSerialInt : 1'b1; // [RULE17]
	assign txIrPin     = txOn ? txIrInt : 1'b0;
	assign rxSerialInt = loopMode ? txSerialInt : rxSerialPin; // [RULE16]
	assign rxIrInt     = loopMode ? txIrInt : rxIrPin;

	// internal modem status sources during loopback
	assign ctsInt = ~loopMode ? ctsPin : mcrQ[`UBD_MCR_RTS]; // [RULE18]
	assign dsrInt = ~loopMode ? dsrPin : mcrQ[`UBD_MCR_DTR];
	assign riInt  = ~loopMode ? riPin
		: (extMode ? mcrQ[`UBD_MCR_DTR] : mcrQ[`UBD_MCR_OUT1]); // [RULE15]
	assign dcdInt = ~loopMode ? dcdPin
		: (extMode ? mcrQ[`UBD_MCR_RTS] : mcrQ[`UBD_MCR_OUT2]);

	// test routing of 16x clock to terminal-ready pin
	assign dtrPin = ext1Q[`UBD_EXT1_BAUD_GENERATOR_TEST_BIT] ? baudX16 // [RULE20]
		: (loopMode ? 1'b0 : mcrQ[`UBD_MCR_DTR]);
	assign rtsPin = loopMode ? 1'b0 : mcrQ[`UBD_MCR_RTS];

endmodule
`default_nettype wire

// ### bench/ubd_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checker of the divisor block
// ----------------------------------------
module ubd_checker (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_we_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic       wb_ack_o,
	input wire logic       dataPortRdStb,
	input wire logic       dataPortWrStb,
	input wire logic       txSerialInt,
	input wire logic       txSerialPin,
	input wire logic       rxSerialPin,
	input wire logic       rxSerialInt,
	input wire logic       ctsInt,
	input wire logic       dsrInt,
	input wire logic       riInt,
	input wire logic       dcdInt,
	input wire logic       extMode,
	input wire logic       loopEn,
	input wire logic [7:0] lineCtrl
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// bus answer: one wait state, one-cycle ack
	a_ack_taken: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	// data port strobes only in bank 0 at offset 0
	a_wrstb_bank: assert property (dataPortWrStb |-> !lineCtrl[7] && wb_adr_i[4:2] == 3'h0 && wb_we_i)
		else $error("data write strobe outside data port");
	a_rdstb_bank: assert property (dataPortRdStb |-> !lineCtrl[7] && wb_adr_i[4:2] == 3'h0 && !wb_we_i)
		else $error("data read strobe outside data port");
	// serial routing with and without loopback, modem status pairs in extended loopback
	a_tx_normal: assert property (!loopEn |-> txSerialPin == txSerialInt)
		else $error("tx pin differs from transmitter");
	a_rx_loop: assert property (loopEn |-> rxSerialInt == txSerialInt)
		else $error("loopback receiver not fed by transmitter");
	a_rx_free: assert property (!loopEn |-> rxSerialInt == rxSerialPin)
		else $error("receiver not fed by pin");
	a_ext_pairs: assert property (loopEn && extMode |-> dsrInt == riInt && ctsInt == dcdInt)
		else $error("extended loopback status pairs differ");
	// mode leaves extended only at an acknowledged access
	a_mode_drop: assert property ($fell(extMode) |-> wb_ack_o)
		else $error("extended mode dropped without access");
endmodule
`default_nettype wire

// ### bench/ubd_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// serial and modem far side
// ----------------------------------------
module ubd_line_model (
	input  wire logic clk,
	input  wire logic rst_n,
	output wire logic txSerialInt,
	output wire logic txIrInt,
	output wire logic rxSerialPin,
	output wire logic rxIrPin,
	output wire logic ctsPin,
	output wire logic dsrPin,
	output wire logic riPin,
	output wire logic dcdPin
);
	logic [2:0] cntQ;
	// free pattern so every line keeps changing
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) cntQ <= 3'h0;
		else cntQ <= cntQ + 3'h1;
	end
	// receive lines differ from transmit lines on purpose
	assign txSerialInt = cntQ[0];
	assign txIrInt     = ~cntQ[0];
	assign rxSerialPin = cntQ[1];
	assign rxIrPin     = ~cntQ[1];
	assign ctsPin      = cntQ[2];
	assign dsrPin      = ~cntQ[2];
	assign riPin       = cntQ[1];
	assign dcdPin      = cntQ[0];
endmodule
`default_nettype wire

// ### bench/test_uart_baud_divisor_fallback_loopback.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// self-checking bench
// ----------------------------------------
module test_uart_baud_divisor_fallback_loopback;
	logic        clk, rst_n, cyc, stb, we, wb_ack_o, baudX16, dtrPin, extMode, loopEn;
	logic        txSerialInt, txIrInt, rxSerialPin, rxIrPin, ctsPin, dsrPin, riPin, dcdPin;
	logic        txSerialPin, txIrPin, rxIrInt;
	logic [4:0]  adr;
	logic [7:0]  modemCtrl, wrData;
	logic [31:0] wdat, rdo, rdat;
	integer      error_cnt, comparisons, cycCnt, p, i;
	logic [1:0]  codes [0:2] = '{2'h0, 2'h1, 2'h3};
	logic [15:0] divs [0:2] = '{16'h0001, 16'h0008, 16'h000D};

	ubd_top i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdo), .wb_ack_o(wb_ack_o),
		.dataPortRd(8'hC3), .dataPortRdStb(), .dataPortWrStb(), .dataPortWrData(wrData),
		.txFifoLevel(5'h05), .rxFifoLevel(5'h0A), .txSerialInt(txSerialInt), .txIrInt(txIrInt),
		.txSerialPin(txSerialPin), .txIrPin(txIrPin), .rxSerialPin(rxSerialPin),
		.rxIrPin(rxIrPin), .rxSerialInt(), .rxIrInt(rxIrInt), .ctsPin(ctsPin), .dsrPin(dsrPin),
		.riPin(riPin), .dcdPin(dcdPin), .ctsInt(), .dsrInt(), .riInt(), .dcdInt(),
		.dtrPin(dtrPin), .rtsPin(), .baudX16(baudX16), .extMode(extMode), .loopEn(loopEn),
		.lineCtrl(), .modemCtrl(modemCtrl));
	ubd_line_model i_line (.clk(clk), .rst_n(rst_n), .txSerialInt(txSerialInt),
		.txIrInt(txIrInt), .rxSerialPin(rxSerialPin), .rxIrPin(rxIrPin), .ctsPin(ctsPin),
		.dsrPin(dsrPin), .riPin(riPin), .dcdPin(dcdPin));

	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycCnt = cycCnt + 1;
		if (cycCnt == 20000) begin
			error_cnt = error_cnt + 1;
			final_report;
		end
	end

	task final_report;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons = comparisons + 1;
		if (g !== e) begin
			error_cnt = error_cnt + 1;
			$display("wrong value %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	// one classic cycle, held until ack is sampled
	task wb(input logic w, input logic [2:0] a, input logic [7:0] d);
		integer n;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {a, 2'b00};
		wdat <= {24'h0, d};
		n = 0;
		@(posedge clk);
		while (wb_ack_o !== 1'b1 && n < 50) begin
			n = n + 1;
			@(posedge clk);
		end
		rdat = rdo;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask
	// cycles between two 16x pulses
	task period;
		integer n;
		repeat (2) begin
			n = 0;
			@(posedge clk);
			while (baudX16 !== 1'b1 && n < 500) begin
				n = n + 1;
				@(posedge clk);
			end
		end
		p = 0;
		do begin
			@(posedge clk);
			p = p + 1;
		end while (baudX16 !== 1'b1 && p < 500);
	endtask

	task tReset;
		wb(1, 3, 8'hE0);
		wb(0, 2, 8'h00); chk("ext1 reset", 0, rdat);
		chk("extMode reset", 0, extMode);
		$display("reset test done");
	endtask
	task tBaud;
		for (i = 0; i < 3; i++) begin
			wb(1, 4, {2'h0, codes[i], 4'h0});
			wb(1, 1, divs[i][15:8]);
			wb(1, 0, divs[i][7:0]);
			period; chk("x16 period", 13, p);
		end
		$display("baud test done");
	endtask
	task tFallback;
		for (i = 0; i < 2; i++) begin
			wb(1, 3, 8'hE0);
			wb(1, 4, 8'h30);
			wb(1, 2, 8'hB0 | i[7:0]);
			wb(1, 3, 8'h03);
			wb(1, 4, 8'hFF);
			wb(1, 3, 8'h83);
			wb(1, 0, 8'h0D);
			chk("extMode", 0, extMode);
			if (i == 1) chk("modem bits", 0, modemCtrl & 8'hFC);
			wb(1, 3, 8'hE0);
			wb(0, 2, 8'h00); chk("ext1", 8'h10, rdat);
			wb(0, 4, 8'h00); chk("ext2", 0, rdat);
		end
		$display("fallback test done");
	endtask
	task tLock;
		wb(1, 2, 8'h00);
		wb(1, 4, 8'h80);
		wb(1, 3, 8'h83);
		wb(1, 0, 8'h5A);
		wb(1, 1, 8'hA5);
		wb(0, 0, 8'h00); chk("pad low", 8'h5A, rdat);
		wb(0, 1, 8'h00); chk("pad high", 8'hA5, rdat);
		period; chk("locked period", 169, p);
		wb(1, 3, 8'hE0);
		wb(0, 4, 8'h00); chk("ext2 lock", 8'h80, rdat);
		wb(1, 4, 8'h00);
		$display("lock test done");
	endtask
	task tLoop;
		wb(1, 2, 8'h10);
		chk("loopEn", 1, loopEn);
		chk("tx pin", 1, txSerialPin);
		chk("ir pin", 0, txIrPin);
		chk("ir rx", txIrInt, rxIrInt);
		wb(1, 2, 8'h30);
		repeat (2) begin
			@(posedge clk); chk("tx pin", txSerialInt, txSerialPin);
		end
		wb(1, 2, 8'h80);
		repeat (340) begin
			@(posedge clk); chk("dtr", baudX16, dtrPin);
		end
		wb(1, 2, 8'h00);
		$display("loopback test done");
	endtask
	task tData;
		wb(1, 3, 8'h03);
		wb(1, 0, 8'h3C); chk("data out", 8'h3C, wrData);
		wb(0, 0, 8'h00); chk("data in", 8'hC3, rdat);
		wb(1, 3, 8'h83);
		wb(0, 0, 8'h00); chk("divisor low", 8'h0D, rdat);
		$display("data port test done");
	endtask

	// main sequence, divisors never zero
	initial begin
		rst_n = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 5'h00;
		wdat = 32'h0;
		error_cnt = 0;
		comparisons = 0;
		cycCnt = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		tReset;
		tBaud;
		tFallback;
		tLock;
		tLoop;
		tData;
		final_report;
	end
endmodule

bind ubd_top ubd_checker i_chk (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o),
	.dataPortRdStb(dataPortRdStb), .dataPortWrStb(dataPortWrStb), .txSerialInt(txSerialInt),
	.txSerialPin(txSerialPin), .rxSerialPin(rxSerialPin), .rxSerialInt(rxSerialInt),
	.ctsInt(ctsInt), .dsrInt(dsrInt), .riInt(riInt), .dcdInt(dcdInt), .extMode(extMode),
	.loopEn(loopEn), .lineCtrl(lineCtrl));
`default_nettype wire
